// ==== srpr_regs.sv ====
// sensor reset and frequency synthesiser register bank, apb slave
//
// Summary of operation
// [RULE_01] two-bit read-write variant select, reset zero, one of four codes
// [RULE_02] synthesiser held in soft reset while its code field equals 0x9
// [RULE_03] lock detector held in soft reset while bits 7:4 equal 0x9
// [RULE_04] clock generator held in soft reset while its code equals 0x9
// [RULE_05] analog front end held in soft reset while bits 7:4 equal 0x9
// [RULE_06] serializer (bits 11:8) and column mux (bits 3:0) reset on 0x9
// [RULE_07] synthesiser powered down while power bit 0 is zero
// [RULE_08] synthesiser disabled while power bit 1 is zero
// [RULE_09] synthesiser bypassed while power bit 2 is one, its reset value
// [RULE_10] fixed identification word at index zero; writes to 0 and 1 ignored
// [RULE_11] software releases soft resets only after power and enable are set; the holds here follow their code fields alone
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module srpr_regs
  import srpr_pkg::*;
#(
  parameter logic [15:0] DEVICE_ID = 16'h1a2b // arbitrary value
)(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // variant select
  output logic [VARIANT_W-1:0]   variant_sel,
  // soft reset holds
  output logic                   synth_hold,
  output logic                   lockdet_hold,
  output logic                   clockgen_hold,
  output logic                   colmux_hold,
  output logic                   frontend_hold,
  output logic                   serializer_hold,
  // synthesiser controls
  output logic                   synth_power_up,
  output logic                   synth_enable,
  output logic                   synth_bypass,
  output logic [M_W-1:0]         synth_mdiv,
  output logic [N_W-1:0]         synth_ndiv,
  output logic [P_W-1:0]         synth_pdiv
);

  typedef struct packed {
    srpr_bus_e             bus;
    logic                  ready;
    logic                  slverr;
    logic [DATA_W-1:0]     rdata;
    logic [VARIANT_W-1:0]  variant;
    logic [SRST_W-1:0]     synth_rst;
    logic [CRST_W-1:0]     cgen_rst;
    logic [FRST_W-1:0]     fe_rst;
    logic [PWR_W-1:0]      pwr;
    logic [DIV_W-1:0]      div;
    logic                  h_synth;
    logic                  h_lockdet;
    logic                  h_clockgen;
    logic                  h_colmux;
    logic                  h_frontend;
    logic                  h_serial;
  } srpr_state_s;

  srpr_state_s       cur;
  srpr_state_s       next_cur;
  logic [IDX_W-1:0]  idx;
  logic              mapped;
  logic [DATA_W-1:0] read_val;
  logic              wr_go;

  srpr_addr_decode u_dec (
    .paddr  (paddr),
    .idx    (idx),
    .mapped (mapped)
  );

  // write commits only on the edge that completes an access
  assign wr_go = psel && penable && cur.ready && pwrite;

  // read mux, unused bits read zero
  always_comb begin
    read_val = '0;
    case (idx)
      IDX_DEVICE_ID: read_val = DATA_W'(DEVICE_ID); // RULE_10
      IDX_RESERVED:  read_val = '0; // RULE_10
      IDX_VARIANT:   read_val = DATA_W'(cur.variant);
      IDX_SYNTH_RST: read_val = DATA_W'(cur.synth_rst);
      IDX_CGEN_RST:  read_val = DATA_W'(cur.cgen_rst);
      IDX_FE_RST:    read_val = DATA_W'(cur.fe_rst);
      IDX_SYNTH_PWR: read_val = DATA_W'(cur.pwr);
      IDX_SYNTH_DIV: read_val = DATA_W'(cur.div);
      default:       read_val = '0;
    endcase
    if (!mapped) begin
      read_val = '0;
    end
  end

  always_comb begin
    next_cur       = cur;
    next_cur.ready = 1'b0;
    next_cur.bus   = SRPR_IDLE;
    case (cur.bus)
      SRPR_IDLE: begin
        if (psel && !penable) begin
          next_cur.bus    = SRPR_ANSWER;
          next_cur.ready  = 1'b1;
          next_cur.slverr = !mapped;
          next_cur.rdata  = pwrite ? '0 : read_val;
        end
      end
      SRPR_ANSWER: begin
        if (wr_go && mapped) begin
          case (idx)
            IDX_VARIANT:
              next_cur.variant = pwdata[VARIANT_W-1:0]; // RULE_01
            IDX_SYNTH_RST:
              next_cur.synth_rst = pwdata[SRST_W-1:0];
            IDX_CGEN_RST:
              next_cur.cgen_rst = pwdata[CRST_W-1:0];
            IDX_FE_RST:
              next_cur.fe_rst = pwdata[FRST_W-1:0];
            IDX_SYNTH_PWR:
              next_cur.pwr = pwdata[PWR_W-1:0];
            IDX_SYNTH_DIV:
              next_cur.div = pwdata[DIV_W-1:0];
            default: begin
              // identification and reserved words ignore writes
              next_cur.pwr = cur.pwr; // RULE_10
            end
          endcase
        end
        next_cur.slverr = 1'b0;
      end
      default: begin
        next_cur.bus = SRPR_IDLE;
      end
    endcase
    // soft reset holds follow the code fields
    next_cur.h_synth =
      srpr_in_reset(next_cur.synth_rst[POS_SYNTH +: CODE_W]); // RULE_02
    next_cur.h_lockdet =
      srpr_in_reset(next_cur.synth_rst[POS_LOCKDET +: CODE_W]); // RULE_03
    next_cur.h_clockgen =
      srpr_in_reset(next_cur.cgen_rst[POS_CLOCKGEN +: CODE_W]); // RULE_04
    next_cur.h_frontend =
      srpr_in_reset(next_cur.fe_rst[POS_FRONTEND +: CODE_W]); // RULE_05
    next_cur.h_serial =
      srpr_in_reset(next_cur.fe_rst[POS_SERIAL +: CODE_W]); // RULE_06
    next_cur.h_colmux =
      srpr_in_reset(next_cur.fe_rst[POS_COLMUX +: CODE_W]); // RULE_06
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur.bus        <= SRPR_IDLE;
      cur.ready      <= 1'b0;
      cur.slverr     <= 1'b0;
      cur.rdata      <= '0;
      cur.variant    <= RST_VARIANT;
      cur.synth_rst  <= RST_SYNTH_RST;
      cur.cgen_rst   <= RST_CGEN_RST;
      cur.fe_rst     <= RST_FE_RST;
      cur.pwr        <= RST_SYNTH_PWR;
      cur.div        <= RST_SYNTH_DIV;
      cur.h_synth    <= 1'b1;
      cur.h_lockdet  <= 1'b1;
      cur.h_clockgen <= 1'b1;
      cur.h_colmux   <= 1'b1;
      cur.h_frontend <= 1'b1;
      cur.h_serial   <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from state
  assign prdata          = cur.rdata;
  assign pready          = cur.ready;
  assign pslverr         = cur.slverr;
  assign variant_sel     = cur.variant;
  assign synth_hold      = cur.h_synth;
  assign lockdet_hold    = cur.h_lockdet;
  assign clockgen_hold   = cur.h_clockgen;
  assign colmux_hold     = cur.h_colmux;
  assign frontend_hold   = cur.h_frontend;
  assign serializer_hold = cur.h_serial;
  assign synth_power_up  = cur.pwr[BIT_POWER_UP]; // RULE_07
  assign synth_enable    = cur.pwr[BIT_ENABLE]; // RULE_08
  assign synth_bypass    = cur.pwr[BIT_BYPASS]; // RULE_09
  assign synth_mdiv      = cur.div[M_LSB +: M_W];
  assign synth_ndiv      = cur.div[N_LSB +: N_W];
  assign synth_pdiv      = cur.div[P_LSB +: P_W];

  // bus answers
  a_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready
  ) else $error("pready stood longer than one cycle");

  a_setup_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pready |=> pready
  ) else $error("setup cycle not answered next cycle");

  a_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pready && !mapped |=> pslverr && prdata == '0
  ) else $error("unmapped access not flagged");

  a_variant_write: assert property ( // RULE_01
    @(posedge pclk) disable iff (!presetn)
    wr_go && mapped && idx == IDX_VARIANT
      |=> variant_sel == $past(pwdata[VARIANT_W-1:0])
  ) else $error("variant select did not take written code");

  a_synth_hold: assert property ( // RULE_02
    @(posedge pclk) disable iff (!presetn)
    wr_go && mapped && idx == IDX_SYNTH_RST
      |=> synth_hold == ($past(pwdata[3:0]) == SOFT_RESET_CODE)
  ) else $error("synthesiser hold wrong after write");

  a_lockdet_hold: assert property ( // RULE_03
    @(posedge pclk) disable iff (!presetn)
    wr_go && mapped && idx == IDX_SYNTH_RST
      |=> lockdet_hold == ($past(pwdata[7:4]) == SOFT_RESET_CODE)
  ) else $error("lock detector hold wrong after write");

  a_clockgen_hold: assert property ( // RULE_04
    @(posedge pclk) disable iff (!presetn)
    wr_go && mapped && idx == IDX_CGEN_RST
      |=> clockgen_hold == ($past(pwdata[3:0]) == SOFT_RESET_CODE)
  ) else $error("clock generator hold wrong after write");

  a_frontend_hold: assert property ( // RULE_05
    @(posedge pclk) disable iff (!presetn)
    wr_go && mapped && idx == IDX_FE_RST
      |=> frontend_hold == ($past(pwdata[7:4]) == SOFT_RESET_CODE)
  ) else $error("front end hold wrong after write");

  a_serial_hold: assert property ( // RULE_06
    @(posedge pclk) disable iff (!presetn)
    wr_go && mapped && idx == IDX_FE_RST
      |=> serializer_hold == ($past(pwdata[11:8]) == SOFT_RESET_CODE)
        && colmux_hold == ($past(pwdata[3:0]) == SOFT_RESET_CODE)
  ) else $error("serializer or column mux hold wrong after write");

  a_power_bits: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    wr_go && mapped && idx == IDX_SYNTH_PWR
      |=> synth_power_up == $past(pwdata[0])
  ) else $error("power up bit not applied");

  a_enable_bit: assert property ( // RULE_08
    @(posedge pclk) disable iff (!presetn)
    wr_go && mapped && idx == IDX_SYNTH_PWR
      |=> synth_enable == $past(pwdata[1])
  ) else $error("enable bit not applied");

  a_bypass_bit: assert property ( // RULE_09
    @(posedge pclk) disable iff (!presetn)
    wr_go && mapped && idx == IDX_SYNTH_PWR
      |=> synth_bypass == $past(pwdata[2])
  ) else $error("bypass bit not applied");

  a_id_read: assert property ( // RULE_10
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pready && !pwrite && paddr == '0
      |=> pready && prdata == DATA_W'(DEVICE_ID) && !pslverr
  ) else $error("identification word not returned");

  a_ro_write: assert property ( // RULE_10
    @(posedge pclk) disable iff (!presetn)
    wr_go && mapped && (idx == IDX_DEVICE_ID || idx == IDX_RESERVED)
      |=> $stable(variant_sel) && $stable(synth_bypass)
        && $stable(synth_hold) && $stable(serializer_hold)
  ) else $error("write to read-only word changed state");

  a_ready_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready
  ) else $error("error flag raised without pready");

  a_idle_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    !psel |=> !pready
  ) else $error("pready raised without a selected transfer");

  a_write_rdata: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pready && pwrite |=> prdata == '0
  ) else $error("write answer carried read data");

  a_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pready
      |=> prdata[DATA_W-1:$bits(DEVICE_ID)] == '0
  ) else $error("unused read bits not zero");

  a_unmapped_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_go && !mapped
      |=> $stable(variant_sel) && $stable(synth_power_up)
        && $stable(clockgen_hold) && $stable(frontend_hold)
  ) else $error("refused write changed state");

  a_variant_read: assert property ( // RULE_01
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pready && !pwrite && mapped
      && idx == IDX_VARIANT
      |=> prdata[VARIANT_W-1:0] == variant_sel
  ) else $error("variant read back differs from output");

  a_synth_read: assert property ( // RULE_02
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pready && !pwrite && mapped
      && idx == IDX_SYNTH_RST
      |=> synth_hold ==
            (prdata[POS_SYNTH +: CODE_W] == SOFT_RESET_CODE)
        && lockdet_hold ==
            (prdata[POS_LOCKDET +: CODE_W] == SOFT_RESET_CODE)
  ) else $error("synthesiser holds differ from their codes");

  a_clockgen_read: assert property ( // RULE_04
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pready && !pwrite && mapped
      && idx == IDX_CGEN_RST
      |=> clockgen_hold ==
            (prdata[POS_CLOCKGEN +: CODE_W] == SOFT_RESET_CODE)
  ) else $error("clock generator hold differs from its code");

  a_frontend_read: assert property ( // RULE_05
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pready && !pwrite && mapped
      && idx == IDX_FE_RST
      |=> frontend_hold ==
            (prdata[POS_FRONTEND +: CODE_W] == SOFT_RESET_CODE)
        && colmux_hold ==
            (prdata[POS_COLMUX +: CODE_W] == SOFT_RESET_CODE)
  ) else $error("front end holds differ from their codes");

  a_power_read: assert property ( // RULE_07
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pready && !pwrite && mapped
      && idx == IDX_SYNTH_PWR
      |=> prdata[BIT_POWER_UP] == synth_power_up
        && prdata[BIT_ENABLE] == synth_enable
        && prdata[BIT_BYPASS] == synth_bypass
  ) else $error("power controls differ from their register");

endmodule // srpr_regs

// ==== srpr_pkg.sv ====
// register map, reset values and field layout of the sensor reset/pll bank
package srpr_pkg;

  // apb geometry
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned IDX_W   = ADDR_W - 2;
  localparam int unsigned DATA_W  = 32;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DEVICE_ID   = 6'h00;
  localparam logic [IDX_W-1:0] IDX_RESERVED    = 6'h01;
  localparam logic [IDX_W-1:0] IDX_VARIANT     = 6'h02;
  localparam logic [IDX_W-1:0] IDX_SYNTH_RST   = 6'h08;
  localparam logic [IDX_W-1:0] IDX_CGEN_RST    = 6'h09;
  localparam logic [IDX_W-1:0] IDX_FE_RST      = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_SYNTH_PWR   = 6'h10;
  localparam logic [IDX_W-1:0] IDX_SYNTH_DIV   = 6'h11;

  // stored widths
  localparam int unsigned VARIANT_W = 2;
  localparam int unsigned CODE_W    = 4;
  localparam int unsigned SRST_W    = 8;
  localparam int unsigned CRST_W    = 4;
  localparam int unsigned FRST_W    = 12;
  localparam int unsigned PWR_W     = 3;
  localparam int unsigned DIV_W     = 15;

  // reset values
  localparam logic [VARIANT_W-1:0] RST_VARIANT   = 2'h0;
  localparam logic [SRST_W-1:0]    RST_SYNTH_RST = 8'h99;
  localparam logic [CRST_W-1:0]    RST_CGEN_RST  = 4'h9;
  localparam logic [FRST_W-1:0]    RST_FE_RST    = 12'h999;
  localparam logic [PWR_W-1:0]     RST_SYNTH_PWR = 3'h4;
  localparam logic [DIV_W-1:0]     RST_SYNTH_DIV = 15'h2113;

  // code that holds a unit in soft reset
  localparam logic [CODE_W-1:0] SOFT_RESET_CODE = 4'h9;

  // code field positions
  localparam int unsigned POS_SYNTH    = 0;
  localparam int unsigned POS_LOCKDET  = 4;
  localparam int unsigned POS_CLOCKGEN = 0;
  localparam int unsigned POS_COLMUX   = 0;
  localparam int unsigned POS_FRONTEND = 4;
  localparam int unsigned POS_SERIAL   = 8;

  // power register bits
  localparam int unsigned BIT_POWER_UP = 0;
  localparam int unsigned BIT_ENABLE   = 1;
  localparam int unsigned BIT_BYPASS   = 2;

  // divider fields
  localparam int unsigned M_LSB = 0;
  localparam int unsigned M_W   = 8;
  localparam int unsigned N_LSB = 8;
  localparam int unsigned N_W   = 5;
  localparam int unsigned P_LSB = 13;
  localparam int unsigned P_W   = 2;

  typedef enum logic {SRPR_IDLE, SRPR_ANSWER} srpr_bus_e;

  // true while a code field keeps its unit in soft reset
  function automatic logic srpr_in_reset(input logic [CODE_W-1:0] code);
    return code == SOFT_RESET_CODE;
  endfunction

endpackage

// ==== srpr_addr_decode.sv ====
// apb byte address to register index decode
`timescale 1ns/1ns
module srpr_addr_decode
  import srpr_pkg::*;
(
  // bus address
  input  wire logic [ADDR_W-1:0] paddr,
  // decoded
  output logic      [IDX_W-1:0]  idx,
  output logic                   mapped
);

  always_comb begin
    idx    = paddr[ADDR_W-1:2];
    mapped = 1'b0;
    if (paddr[1:0] == 2'b00) begin
      case (idx)
        IDX_DEVICE_ID,
        IDX_RESERVED,
        IDX_VARIANT,
        IDX_SYNTH_RST,
        IDX_CGEN_RST,
        IDX_FE_RST,
        IDX_SYNTH_PWR,
        IDX_SYNTH_DIV: mapped = 1'b1;
        default:       mapped = 1'b0;
      endcase
    end
  end

endmodule // srpr_addr_decode

// ==== srpr_tb.sv ====
// self-checking apb testbench for the sensor reset and synthesiser bank
`timescale 1ns/1ns
module testbench;
  import srpr_pkg::*;
  // byte addresses of the bank
  localparam logic [7:0] A_ID  = 8'h00;
  localparam logic [7:0] A_RSV = 8'h04;
  localparam logic [7:0] A_VAR = 8'h08;
  localparam logic [7:0] A_SR  = 8'h20;
  localparam logic [7:0] A_CG  = 8'h24;
  localparam logic [7:0] A_FE  = 8'h28;
  localparam logic [7:0] A_PWR = 8'h40;
  localparam logic [7:0] A_DIV = 8'h44;
  localparam logic [15:0] ID_VAL = 16'h3c5d; // arbitrary value

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic [1:0]        variant_sel;
  logic              synth_hold;
  logic              lockdet_hold;
  logic              clockgen_hold;
  logic              colmux_hold;
  logic              frontend_hold;
  logic              serializer_hold;
  logic              synth_power_up;
  logic              synth_enable;
  logic              synth_bypass;
  logic [M_W-1:0]    synth_mdiv;
  logic [N_W-1:0]    synth_ndiv;
  logic [P_W-1:0]    synth_pdiv;
  int                mismatches;
  int                checks_done;
  // soft reset code table: address, data, holds
  logic [7:0]        ta [6] = '{A_SR, A_SR, A_CG, A_CG, A_FE, A_FE};
  logic [31:0]       td [6] = '{32'h89, 32'h98, 32'h0, 32'h9,
                                32'h99a, 32'h0a9};
  logic [5:0]        th [6] = '{6'b101111, 6'b011111, 6'b010111,
                                6'b011111, 6'b011011, 6'b011100};
  logic [2:0]        tp [4] = '{3'h3, 3'h0, 3'h7, 3'h4};

  srpr_regs #(.DEVICE_ID(ID_VAL)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .variant_sel(variant_sel),
    .synth_hold(synth_hold), .lockdet_hold(lockdet_hold),
    .clockgen_hold(clockgen_hold), .colmux_hold(colmux_hold),
    .frontend_hold(frontend_hold), .serializer_hold(serializer_hold),
    .synth_power_up(synth_power_up), .synth_enable(synth_enable),
    .synth_bypass(synth_bypass), .synth_mdiv(synth_mdiv),
    .synth_ndiv(synth_ndiv), .synth_pdiv(synth_pdiv)
  );

  always #25 pclk = ~pclk;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one apb transfer: setup, access until pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED pready expected 1 seen timeout");
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic x);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    check("write error", {31'h0, e}, {31'h0, x});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check("read data", r, x);
    check("read error", {31'h0, e}, {31'h0, xe});
  endtask

  // holds {synth,lock,cgen,mux,afe,ser}, power {bypass,enable,up}
  task automatic outs(input logic [5:0] h, input logic [2:0] p);
    @(negedge pclk);
    check("holds", {26'h0, synth_hold, lockdet_hold, clockgen_hold,
          colmux_hold, frontend_hold, serializer_hold}, {26'h0, h});
    check("power", {29'h0, synth_bypass, synth_enable, synth_power_up},
          {29'h0, p});
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    checks_done = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    outs(6'h3f, 3'h4);
    check("div", {17'h0, synth_pdiv, synth_ndiv, synth_mdiv}, 32'h2113);
    rd(A_VAR, 32'h0, 1'b0);
    rd(A_SR, 32'h99, 1'b0);
    rd(A_CG, 32'h9, 1'b0);
    rd(A_FE, 32'h999, 1'b0);
    rd(A_PWR, 32'h4, 1'b0);
    rd(A_DIV, 32'h2113, 1'b0);
    $display("test reset values done");
    wr(A_ID, 32'hffff_ffff, 1'b0);
    wr(A_RSV, 32'hffff_ffff, 1'b0);
    rd(A_ID, {16'h0, ID_VAL}, 1'b0);
    rd(A_RSV, 32'h0, 1'b0);
    $display("test read-only words done");
    for (int i = 0; i < 4; i++) begin
      wr(A_VAR, 32'hffff_fffc | 32'(i), 1'b0);
      rd(A_VAR, 32'(i), 1'b0);
      check("variant", {30'h0, variant_sel}, 32'(i));
    end
    $display("test variant select done");
    wr(A_PWR, 32'h3, 1'b0);
    wr(A_SR, 32'hffff_ff99, 1'b0);
    rd(A_SR, 32'h99, 1'b0);
    for (int i = 0; i < 6; i++) begin
      wr(ta[i], td[i], 1'b0);
      outs(th[i], 3'h3);
      rd(ta[i], td[i], 1'b0);
    end
    $display("test soft reset codes done");
    for (int i = 0; i < 4; i++) begin
      wr(A_PWR, {29'h0, tp[i]}, 1'b0);
      outs(6'b011100, tp[i]);
      rd(A_PWR, {29'h0, tp[i]}, 1'b0);
    end
    wr(A_DIV, 32'hffff_ffff, 1'b0);
    rd(A_DIV, 32'h7fff, 1'b0);
    check("div", {17'h0, synth_pdiv, synth_ndiv, synth_mdiv}, 32'h7fff);
    $display("test power controls done");
    rd(8'h0c, 32'h0, 1'b1);
    wr(8'h0c, 32'h1, 1'b1);
    rd(8'h21, 32'h0, 1'b1);
    wr(8'h41, 32'h3, 1'b1);
    rd(A_PWR, 32'h4, 1'b0);
    rd(8'hfc, 32'h0, 1'b1);
    $display("test refused accesses done");
    wr(A_VAR, 32'h3, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    outs(6'h3f, 3'h4);
    check("variant", {30'h0, variant_sel}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    rd(A_FE, 32'h999, 1'b0);
    $display("test second reset done");
    results();
  end
endmodule // testbench
